// File: rtl/fsps_defs.svh
// Purpose: constants of the flash self-program sequencer
// Assumes: 16-bit pointer, 32-word pages, 128 pages
// Notes: bit positions refer to the store_program_control byte
`ifndef FSPS_DEFS_SVH
`define FSPS_DEFS_SVH
`define FSPS_CTL_EN 0
`define FSPS_CTL_ERASE 1
`define FSPS_CTL_WRITE 2
`define FSPS_CTL_LOCKSET 3
`define FSPS_CTL_REEN 4
`define FSPS_CTL_BUSY 6
`define FSPS_CTL_IE 7
`define FSPS_CMD_LOAD 5'h01
`define FSPS_CMD_ERASE 5'h03
`define FSPS_CMD_WRITE 5'h05
`define FSPS_CMD_LOCK 5'h09
`define FSPS_CMD_REEN 5'h11
`define FSPS_SPM_WIN 3'h4
`define FSPS_LPM_WIN 3'h3
`define FSPS_Z_LOCK 16'h0001
`define FSPS_Z_FLOW 16'h0000
`define FSPS_Z_FHIGH 16'h0003
`define FSPS_APP_RESET 12'h000
`define FSPS_BOOT_RESET 12'hC00
`define FSPS_RWW_PAGES 7'h60
`define FSPS_BUF_ERASED 16'hFFFF
`endif

// File: rtl/fsps_pkg.sv
// Purpose: types of the flash self-program sequencer
// Assumes: fsps_defs.svh holds every number
// Notes: none
package fsps_pkg;
  typedef enum logic [1:0] {FSPS_IDLE, FSPS_RUN} fsps_state_t;
  typedef enum logic [1:0] {FSPS_OP_ERASE, FSPS_OP_WRITE, FSPS_OP_LOCK} fsps_op_t;
endpackage

// File: rtl/fsps_sequencer.sv
// Purpose: flash self-program sequencer (page buffer, erase, write, locks)
// Assumes: CPU strobes and flash done come from the same clock; fuses
//   and lock states arrive from pins and are synchronised
// Notes: programming time is measured by the flash macro via opDone
`include "fsps_defs.svh"
module fsps_sequencer
  import fsps_pkg::*;
#(
  parameter int PAGE_BITS = 7,
  parameter int WORD_BITS = 5
)
(
  input wire logic clk,                         // 10 MHz clock
  input wire logic reset,                       // Synchronous, active high
  input wire logic ctrlWrite,                   // CPU writes control byte
  input wire logic [7:0] ctrlWrData,            // Control byte written
  input wire logic spmStrobe,                   // Store-program instruction
  input wire logic lpmStrobe,                   // Load-program instruction
  input wire logic [15:0] zPtr,                 // Flash address pointer
  input wire logic [7:0] r0,                    // Data pair low
  input wire logic [7:0] r1,                    // Data pair high
  input wire logic [15:0] flashWord,            // Flash word at zPtr[15:1]
  input wire logic eepromWriteActive,           // EEPROM write running
  input wire logic opDone,                      // Flash macro finished op
  input wire logic [WORD_BITS-1:0] bufRdIdx,    // Flash macro reads buffer
  input wire logic [7:0] fuseLowProg,           // Pin: 1 = fuse programmed
  input wire logic [7:0] fuseHighProg,          // Pin: 1 = fuse programmed
  input wire logic bootResetProg,               // Pin: boot reset fuse programmed
  input wire logic [3:0] lockProg,              // Pin: boot locks 5:2 programmed
  output logic [7:0] ctrlRdData,                // Control byte read back
  output logic [7:0] lpmData,                   // Load-program result
  output logic lpmValid,                        // Result pulse
  output logic eraseStart,                      // Pulse: start page erase
  output logic writeStart,                      // Pulse: start page write
  output logic lockStart,                       // Pulse: program lock bits
  output logic [3:0] lockMask,                  // Locks 5:2 to program
  output logic [PAGE_BITS-1:0] opPage,          // Latched target page
  output logic [15:0] bufRdData,                // Buffer word for flash macro
  output logic cpuHalt,                         // Stall the CPU
  output logic rwwBlocked,                      // Concurrent section unreadable
  output logic intReq,                          // Store-program interrupt
  output logic [11:0] resetVector               // Word reset address
);
  localparam int WORDS = 1 << WORD_BITS;

  // ==========================================================
  // State
  typedef struct packed {
    fsps_state_t state;
    fsps_op_t op;
    logic [7:0] ctl;
    logic [2:0] win;
    logic [WORDS-1:0][15:0] buf_w;
    logic bufDirty;
    logic eeDly;
    logic [7:0] flA;
    logic [7:0] fuse_low_byte;
    logic [7:0] fhA;
    logic [7:0] fuse_high_byte;
    logic [4:0] miscA;
    logic [4:0] miscB;
    logic [7:0] lpmData;
    logic lpmValid;
    logic eraseStart;
    logic writeStart;
    logic lockStart;
    logic [3:0] lockMask;
    logic [PAGE_BITS-1:0] opPage;
    logic [15:0] bufRdData;
    logic cpuHalt;
    logic intReq;
    logic [11:0] resetVector;
  } fsps_regs_t;

  fsps_regs_t st_r;
  fsps_regs_t st_nxt;

  logic [4:0] cmd;
  logic spmOk;
  logic lpmSpecial;
  logic [PAGE_BITS-1:0] zPage;
  logic [WORD_BITS-1:0] zWord;
  logic zHalting;

  assign cmd = st_r.ctl[4:0];
  assign zPage = zPtr[WORD_BITS+PAGE_BITS:WORD_BITS+1];
  assign zWord = zPtr[WORD_BITS:1];
  assign zHalting = zPage >= `FSPS_RWW_PAGES;
  // Timed sequence: the instruction counts only inside its window
  assign spmOk = spmStrobe && st_r.state == FSPS_IDLE && st_r.ctl[`FSPS_CTL_EN]
    && st_r.win < `FSPS_SPM_WIN && !eepromWriteActive;
  assign lpmSpecial = lpmStrobe && st_r.state == FSPS_IDLE
    && cmd == `FSPS_CMD_LOCK && st_r.win < `FSPS_LPM_WIN
    && !eepromWriteActive;

  // ==========================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.eraseStart = 1'b0;
    st_nxt.writeStart = 1'b0;
    st_nxt.lockStart = 1'b0;
    st_nxt.lpmValid = 1'b0;
    // Fuses and lock states only enter through synchronisers; no path
    // exists from software to alter them
    st_nxt.flA = fuseLowProg;
    st_nxt.fuse_low_byte = st_r.flA;
    st_nxt.fhA = fuseHighProg;
    st_nxt.fuse_high_byte = st_r.fhA;
    st_nxt.miscA = {bootResetProg, lockProg};
    st_nxt.miscB = st_r.miscA;
    st_nxt.eeDly = eepromWriteActive;
    st_nxt.resetVector = st_r.miscB[4] ? `FSPS_BOOT_RESET : `FSPS_APP_RESET;
    st_nxt.bufRdData = st_r.buf_w[bufRdIdx];
    st_nxt.intReq = st_r.ctl[`FSPS_CTL_IE] && !st_r.ctl[`FSPS_CTL_EN];

    if (st_r.win != 3'h7)
    begin
      st_nxt.win = st_r.win + 3'h1;
    end

    // Window expiry drops a pending command
    if (st_r.state == FSPS_IDLE && st_r.ctl[`FSPS_CTL_EN] && st_r.win >= `FSPS_SPM_WIN)
    begin
      st_nxt.ctl[4:0] = 5'h00;
    end
    if (st_r.state == FSPS_IDLE && st_r.ctl[`FSPS_CTL_LOCKSET]
        && st_r.win >= `FSPS_LPM_WIN && !spmOk)
    begin
      // No load-program in time: a lock read setup lapses
      st_nxt.ctl[4:0] = 5'h00;
    end

    if (ctrlWrite && st_r.state == FSPS_IDLE)
    begin
      st_nxt.ctl[4:0] = ctrlWrData[4:0];
      st_nxt.ctl[`FSPS_CTL_IE] = ctrlWrData[`FSPS_CTL_IE];
      st_nxt.win = 3'h0;
    end

    if (lpmStrobe)
    begin
      st_nxt.lpmValid = 1'b1;
      st_nxt.lpmData = zPtr[0] ? flashWord[15:8] : flashWord[7:0];
      if (lpmSpecial)
      begin
        st_nxt.ctl[4:0] = 5'h00;
        unique case (zPtr)
          `FSPS_Z_LOCK: st_nxt.lpmData = {2'b11, ~st_r.miscB[3:0], 2'b11};
          `FSPS_Z_FLOW: st_nxt.lpmData = ~st_r.fuse_low_byte;
          `FSPS_Z_FHIGH: st_nxt.lpmData = ~st_r.fuse_high_byte;
          default: st_nxt.lpmData = 8'hFF;
        endcase
      end
    end

    unique case (st_r.state)
      FSPS_IDLE:
      begin
        if (spmOk)
        begin
          unique case (cmd)
            `FSPS_CMD_LOAD:
            begin
              st_nxt.buf_w[zWord] = {r1, r0};
              st_nxt.bufDirty = 1'b1;
              st_nxt.ctl[4:0] = 5'h00;
            end
            `FSPS_CMD_ERASE:
            begin
              // Page only; data pair and low pointer bits are ignored
              st_nxt.opPage = zPage;
              st_nxt.op = FSPS_OP_ERASE;
              st_nxt.eraseStart = 1'b1;
              st_nxt.cpuHalt = zHalting;
              st_nxt.ctl[`FSPS_CTL_BUSY] = 1'b1;
              st_nxt.state = FSPS_RUN;
            end
            `FSPS_CMD_WRITE:
            begin
              st_nxt.opPage = zPage;
              st_nxt.op = FSPS_OP_WRITE;
              st_nxt.writeStart = 1'b1;
              st_nxt.cpuHalt = zHalting;
              st_nxt.ctl[`FSPS_CTL_BUSY] = 1'b1;
              st_nxt.state = FSPS_RUN;
            end
            `FSPS_CMD_LOCK:
            begin
              // Pointer ignored; no section blocked or halted
              st_nxt.lockMask = ~r0[5:2];
              st_nxt.op = FSPS_OP_LOCK;
              st_nxt.lockStart = 1'b1;
              st_nxt.state = FSPS_RUN;
            end
            `FSPS_CMD_REEN:
            begin
              st_nxt.ctl[`FSPS_CTL_BUSY] = 1'b0;
              for (int i = 0; i < WORDS; i++)
              begin
                st_nxt.buf_w[i] = `FSPS_BUF_ERASED;
              end
              st_nxt.bufDirty = 1'b0;
              st_nxt.ctl[4:0] = 5'h00;
            end
            default:
            begin
              st_nxt.ctl[4:0] = 5'h00;
            end
          endcase
        end
      end
      FSPS_RUN:
      begin
        // Enable stays set until the macro reports completion
        if (opDone)
        begin
          st_nxt.state = FSPS_IDLE;
          st_nxt.ctl[4:0] = 5'h00;
          st_nxt.cpuHalt = 1'b0;
          if (st_r.op == FSPS_OP_WRITE)
          begin
            for (int i = 0; i < WORDS; i++)
            begin
              st_nxt.buf_w[i] = `FSPS_BUF_ERASED;
            end
            st_nxt.bufDirty = 1'b0;
          end
        end
      end
      default:
      begin
        st_nxt.state = FSPS_IDLE;
      end
    endcase

    // EEPROM write starting mid-load loses everything loaded so far
    if (eepromWriteActive && !st_r.eeDly && st_r.bufDirty && st_r.state == FSPS_IDLE)
    begin
      for (int i = 0; i < WORDS; i++)
      begin
        st_nxt.buf_w[i] = `FSPS_BUF_ERASED;
      end
      st_nxt.bufDirty = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r <= '0;
      st_r.state <= FSPS_IDLE;
      st_r.op <= FSPS_OP_ERASE;
      st_r.win <= 3'h7;
      for (int i = 0; i < WORDS; i++)
      begin
        st_r.buf_w[i] <= `FSPS_BUF_ERASED;
      end
      st_r.lockMask <= 4'h0;
      st_r.resetVector <= `FSPS_APP_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign ctrlRdData = {st_r.ctl[7:5], 1'b0, st_r.ctl[3:0]};
  assign lpmData = st_r.lpmData;
  assign lpmValid = st_r.lpmValid;
  assign eraseStart = st_r.eraseStart;
  assign writeStart = st_r.writeStart;
  assign lockStart = st_r.lockStart;
  assign lockMask = st_r.lockMask;
  assign opPage = st_r.opPage;
  assign bufRdData = st_r.bufRdData;
  assign cpuHalt = st_r.cpuHalt;
  assign rwwBlocked = st_r.ctl[`FSPS_CTL_BUSY];
  assign intReq = st_r.intReq;
  assign resetVector = st_r.resetVector;
endmodule

// File: verif/fsps_chk.sv
// Purpose: port assertions of the flash self-program sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every sequencer instance
`include "fsps_defs.svh"
module fsps_chk
#(
  parameter int PAGE_BITS = 7,
  parameter int WORD_BITS = 5
)
(
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic [7:0] r0, // Lock data
  input wire logic eepromWriteActive, // EEPROM busy
  input wire logic opDone, // Op finished
  input wire logic [7:0] ctrlRdData, // Control readback
  input wire logic eraseStart, // Erase pulse
  input wire logic writeStart, // Write pulse
  input wire logic lockStart, // Lock pulse
  input wire logic [3:0] lockMask, // Locks to program
  input wire logic [PAGE_BITS-1:0] opPage, // Latched page
  input wire logic cpuHalt, // CPU stall
  input wire logic rwwBlocked, // Section blocked
  input wire logic intReq // Interrupt
);
  // ====================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_lock_mask: assert property (
    lockStart |-> lockMask == ~$past(r0[5:2])) else $error("lock mask wrong");
  a_erase_halt: assert property (
    eraseStart |-> cpuHalt == (opPage >= `FSPS_RWW_PAGES)) else $error("erase halt wrong");
  a_write_halt: assert property (
    writeStart |-> cpuHalt == (opPage >= `FSPS_RWW_PAGES)) else $error("write halt wrong");
  a_halt_release: assert property (
    opDone && cpuHalt |=> !cpuHalt) else $error("halt not released");
  a_busy_block: assert property (
    eraseStart || writeStart |-> rwwBlocked) else $error("section not blocked");
  a_page_hold: assert property (
    cpuHalt && $past(cpuHalt) |-> $stable(opPage)) else $error("page moved");
  a_eeprom_refuse: assert property (
    $past(eepromWriteActive) |-> !(eraseStart || writeStart || lockStart))
    else $error("start during EEPROM write");
  a_int_level: assert property (
    (ctrlRdData[7] && !ctrlRdData[0])[*2] |-> intReq) else $error("interrupt missing");
endmodule
bind fsps_sequencer fsps_chk #(.PAGE_BITS(PAGE_BITS), .WORD_BITS(WORD_BITS)) i_chk (
  .clk, .reset, .r0, .eepromWriteActive, .opDone, .ctrlRdData, .eraseStart,
  .writeStart, .lockStart, .lockMask, .opPage, .cpuHalt, .rwwBlocked, .intReq);

// File: verif/fsps_flash_model.sv
// Purpose: flash macro seen by the sequencer
// Assumes: one operation at a time
// Notes: slow stretches busy time to stall the sequencer
module fsps_flash_model
(
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic [15:0] zPtr, // Read address
  input wire logic start, // Any start pulse
  input wire logic slow, // Long busy time
  output logic [15:0] flashWord, // Word at zPtr
  output logic opDone // Done pulse
);
  int cnt;
  // ====================
  // Address-dependent pattern so byte swaps show up
  assign flashWord = {zPtr[8:1], ~zPtr[8:1]};
  always_ff @(posedge clk)
  begin
    opDone <= 1'h0;
    if (reset)
      cnt <= 0;
    else if (start)
      cnt <= slow ? 40 : 3;
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      opDone <= (cnt == 1);
    end
  end
endmodule

// File: verif/test_flash_self_program_sequencer.sv
// Purpose: self-checking bench of the flash self-program sequencer
// Assumes: flash model answers every start pulse
// Notes: inputs change on the falling edge
`include "fsps_defs.svh"
module test_flash_self_program_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, ctrlWrite, spmStrobe, lpmStrobe, eepromWriteActive, opDone;
  logic bootResetProg, slow, lpmValid, eraseStart, writeStart, lockStart, cpuHalt;
  logic rwwBlocked, intReq;
  logic [7:0] ctrlWrData, r0, r1, fuseLowProg, fuseHighProg, ctrlRdData, lpmData;
  logic [15:0] zPtr, flashWord, bufRdData;
  logic [4:0] bufRdIdx;
  logic [3:0] lockProg, lockMask;
  logic [6:0] opPage;
  logic [11:0] resetVector;
  logic [15:0] bm [32];
  logic [6:0] pg [2] = '{7'h64, 7'h05};
  logic [15:0] fz [3] = '{16'h0000, 16'h0001, 16'h0003};
  logic [7:0] fe [3];
  int n_fail = 0;
  int comparisons = 0;
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  fsps_flash_model i_flash (.clk, .reset, .zPtr, .start(eraseStart | writeStart | lockStart),
    .slow, .flashWord, .opDone);
  fsps_sequencer i_dut (.clk, .reset, .ctrlWrite, .ctrlWrData, .spmStrobe, .lpmStrobe, .zPtr,
    .r0, .r1, .flashWord, .eepromWriteActive, .opDone, .bufRdIdx, .fuseLowProg, .fuseHighProg,
    .bootResetProg, .lockProg, .ctrlRdData, .lpmData, .lpmValid, .eraseStart, .writeStart,
    .lockStart, .lockMask, .opPage, .bufRdData, .cpuHalt, .rwwBlocked, .intReq, .resetVector);
  // ====================
  // Tasks, all entered and left at a falling edge
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ctl(input logic [7:0] v);
    ctrlWrite = 1'h1;
    ctrlWrData = v;
    tk(1);
    ctrlWrite = 1'h0;
  endtask
  task automatic spm(input int g);
    tk(g);
    spmStrobe = 1'h1;
    tk(1);
    spmStrobe = 1'h0;
  endtask
  task automatic lpmchk(input logic [15:0] z, input int g, input logic [7:0] e);
    zPtr = z;
    tk(g);
    lpmStrobe = 1'h1;
    tk(1);
    lpmStrobe = 1'h0;
    check(lpmValid, 1'h1);
    check(lpmData, e);
  endtask
  task automatic load(input int w);
    r0 = 8'($urandom);
    r1 = 8'($urandom);
    zPtr = 16'(w * 2);
    bm[w] = {r1, r0};
    ctl(8'(`FSPS_CMD_LOAD));
    spm($urandom_range(2));
  endtask
  task automatic bufchk();
    for (int w = 0; w < 5; w++)
    begin
      bufRdIdx = 5'(w);
      tk(1);
      check(bufRdData, bm[w]);
    end
  endtask
  task automatic fin();
    int i;
    for (i = 0; i < 300; i++)
    begin
      if (ctrlRdData[0] === 1'h0)
        break;
      tk(1);
    end
    if (i == 300)
    begin
      n_fail++;
      conclude();
    end
    tk(1);
  endtask
  task automatic reen();
    ctl(8'(`FSPS_CMD_REEN));
    spm(0);
    tk(1);
    foreach (bm[i])
      bm[i] = 16'hFFFF;
    bufchk();
  endtask
  initial
  begin
    int unused;
    {ctrlWrite, spmStrobe, lpmStrobe, eepromWriteActive, slow} = 5'h00;
    {ctrlWrData, r0, r1} = 24'h000000;
    zPtr = 16'h0000;
    bufRdIdx = 5'h00;
    bootResetProg = 1'h1;
    reset = 1'h1;
    unused = $urandom(32'h58D6);
    {fuseLowProg, fuseHighProg, lockProg} = 20'($urandom);
    fe = '{~fuseLowProg, {2'h3, ~lockProg, 2'h3}, ~fuseHighProg};
    foreach (bm[i])
      bm[i] = 16'hFFFF;
    tk(3);
    reset = 1'h0;
    check(resetVector, `FSPS_APP_RESET);
    tk(4);
    check(resetVector, `FSPS_BOOT_RESET);
    for (int w = 0; w < 4; w++)
      load(w);
    bufchk();
    eepromWriteActive = 1'h1;
    tk(2);
    foreach (bm[i])
      bm[i] = 16'hFFFF;
    bufchk();
    ctl(8'(`FSPS_CMD_ERASE));
    spm(0);
    check(eraseStart, 1'h0);
    eepromWriteActive = 1'h0;
    tk(6);
    load(2);
    foreach (pg[k])
    begin
      zPtr = {3'h0, pg[k], 6'h00};
      ctl(8'h80 | `FSPS_CMD_ERASE);
      spm(2);
      zPtr = 16'h0000;
      check({eraseStart, rwwBlocked}, 2'h3);
      check(cpuHalt, pg[k] >= `FSPS_RWW_PAGES);
      fin();
      check({opPage, cpuHalt}, {pg[k], 1'h0});
      check({rwwBlocked, intReq}, 2'h3);
      reen();
      check(rwwBlocked, 1'h0);
    end
    load(1);
    slow = 1'h1;
    zPtr = 16'h0140;
    ctl(8'(`FSPS_CMD_WRITE));
    spm(1);
    check({writeStart, cpuHalt, opPage}, {2'h2, 7'h05});
    fin();
    foreach (bm[i])
      bm[i] = 16'hFFFF;
    bufchk();
    check(rwwBlocked, 1'h1);
    reen();
    slow = 1'h0;
    r0 = 8'($urandom);
    ctl(8'(`FSPS_CMD_LOCK));
    spm(2);
    check({lockStart, rwwBlocked, lockMask}, {2'h2, ~r0[5:2]});
    fin();
    foreach (fz[k])
    begin
      ctl(8'(`FSPS_CMD_LOCK));
      lpmchk(fz[k], 1, fe[k]);
      tk(1);
      check(ctrlRdData[3:0], 4'h0);
    end
    zPtr = 16'($urandom);
    tk(1);
    lpmchk(zPtr, 0, zPtr[0] ? flashWord[15:8] : flashWord[7:0]);
    zPtr = 16'h0000;
    ctl(8'(`FSPS_CMD_LOCK));
    lpmchk(16'h0000, 3, flashWord[7:0]);
    conclude();
  end
endmodule
